/* File: hdl/ashs_converter.sv */
// Converter sampling core with register slave
`timescale 1ns/1ns

// Contract
// - Stopping the oscillator halts conversions; no samples appear while stopped.
// - Mode setting selects CCITT frame check and 24-bit words; the reset mode value here selects ANSI frame check and 24-bit words.
// - Ready line timed on laggard channel; high when empty, low when sample ready.
// - Enabling the oscillator last starts sampling.
// - Modulator is crystal halved; sample rate is modulator over oversampling ratio.
module ashs_converter #(
  parameter logic [31:0] DEVICE_ID = 32'h0000_A5C3 // Arbitrary value
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Avalon-MM slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // Converter pins
  input  wire logic        sync_reset_n,
  input  wire logic [23:0] analog_code,
  output logic             conversion_ready_n,
  // Interrupt
  output logic             irq
);
  // Pin synchronisers
  logic        sync_n_s1, sync_n_s2;
  logic [23:0] code_s1, code_s2;

  // Registers
  logic [31:0] mode_config, gain_config_a, gain_config_b;
  logic [31:0] config_reg, channel_config, clock_config;
  logic [31:0] irq_status, irq_mask;
  logic [23:0] sample;
  logic [15:0] crc_value;
  logic [13:0] mod_count;
  logic        ready;

  // Bus decode
  wire         req    = read || write;
  wire         accept = req && !waitrequest;
  wire         wr_acc = accept && write;
  wire         rd_acc = accept && read;
  wire  [31:0] bmask  = {{8{byteenable[3]}}, {8{byteenable[2]}},
                         {8{byteenable[1]}}, {8{byteenable[0]}}};
  wire         wr_mode  = wr_acc && (address == ashs_pkg::ADDR_MODE);
  wire         wr_gna   = wr_acc && (address == ashs_pkg::ADDR_GAIN_A);
  wire         wr_gnb   = wr_acc && (address == ashs_pkg::ADDR_GAIN_B);
  wire         wr_cfg   = wr_acc && (address == ashs_pkg::ADDR_CONFIG);
  wire         wr_chc   = wr_acc && (address == ashs_pkg::ADDR_CHCFG);
  wire         wr_clk   = wr_acc && (address == ashs_pkg::ADDR_CLOCK);
  wire         wr_ist   = wr_acc && (address == ashs_pkg::ADDR_IRQ_ST);
  wire         wr_imk   = wr_acc && (address == ashs_pkg::ADDR_IRQ_MK);
  wire         rd_data  = rd_acc && (address == ashs_pkg::ADDR_DATA);
  wire         soft_rst = !sync_n_s2;

  // Clock register fields
  wire  [7:0]  ch_enable = clock_config[ashs_pkg::CLK_CH_LSB +: 8];
  wire         osc_en    = clock_config[ashs_pkg::CLK_OSC_BIT];
  wire  [2:0]  ovs_code  = clock_config[ashs_pkg::CLK_OVS_LSB +: 3];
  wire  [14:0] ovs_len   = ashs_pkg::OVS_BASE << ovs_code;
  wire  [13:0] ovs_last  = 14'(ovs_len - 15'h0001);
  wire         run       = osc_en && (ch_enable != 8'h00) && !soft_rst;
  wire         ccitt     = mode_config[ashs_pkg::MODE_CRC_BIT];
  wire  [1:0]  wlen      = mode_config[ashs_pkg::MODE_WLEN_LSB +: 2];

  // Modulator enable: crystal halved, rescaled to the system clock
  logic mod_tick;
  ashs_frac_div #(
    .INC (ashs_pkg::MOD_KHZ),
    .MOD (ashs_pkg::CLK_KHZ)
  ) u_mod_div (
    .clk   (clk),
    .reset (reset),
    .run   (run),
    .tick  (mod_tick)
  );

  // One conversion per oversampling length of modulator ticks
  wire sample_tick = run && mod_tick && (mod_count >= ovs_last);

  // Frame check over one 24-bit word, MSB first
  function automatic logic [15:0] crc16(input logic [23:0] d, input logic sel);
    logic [15:0] c;
    logic [15:0] p;
    c = ashs_pkg::CRC_SEED;
    p = sel ? ashs_pkg::CRC_CCITT : ashs_pkg::CRC_ANSI;
    for (int i = 23; i >= 0; i--) begin
      c = (c[15] ^ d[i]) ? ({c[14:0], 1'b0} ^ p) : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // Data word shaped by the word length setting
  wire [31:0] data_word = (wlen == ashs_pkg::WLEN_16)  ? {16'h0000, sample[23:8]} :
                          (wlen == ashs_pkg::WLEN_24)  ? {8'h00, sample} :
                          (wlen == ashs_pkg::WLEN_32Z) ? {sample, 8'h00} :
                                                         {{8{sample[23]}}, sample};

  // Events and interrupt
  wire [31:0] events     = {30'h0, sample_tick && ready, sample_tick};
  wire [31:0] w1c        = wr_ist ? (writedata & bmask) : 32'h0000_0000;
  wire [31:0] next_irq_st = (irq_status & ~w1c) | events;
  wire        next_irq   = |(next_irq_st & irq_mask);

  // Read mux
  wire [31:0] status_word = {30'h0, run, ready};
  wire [31:0] next_rdata =
      (address == ashs_pkg::ADDR_ID)     ? DEVICE_ID :
      (address == ashs_pkg::ADDR_STATUS) ? status_word :
      (address == ashs_pkg::ADDR_MODE)   ? mode_config :
      (address == ashs_pkg::ADDR_GAIN_A) ? gain_config_a :
      (address == ashs_pkg::ADDR_GAIN_B) ? gain_config_b :
      (address == ashs_pkg::ADDR_CONFIG) ? config_reg :
      (address == ashs_pkg::ADDR_CHCFG)  ? channel_config :
      (address == ashs_pkg::ADDR_CLOCK)  ? clock_config :
      (address == ashs_pkg::ADDR_DATA)   ? data_word :
      (address == ashs_pkg::ADDR_CRC)    ? {16'h0000, crc_value} :
      (address == ashs_pkg::ADDR_IRQ_ST) ? irq_status :
      (address == ashs_pkg::ADDR_IRQ_MK) ? irq_mask : 32'h0000_0000;

  // Two-stage synchronisers for pins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync_n_s1 <= 1'b1;
      sync_n_s2 <= 1'b1;
      code_s1   <= 24'h00_0000;
      code_s2   <= 24'h00_0000;
    end else begin
      sync_n_s1 <= sync_reset_n;
      sync_n_s2 <= sync_n_s1;
      code_s1   <= analog_code;
      code_s2   <= code_s1;
    end
  end

  // One wait state, then the access completes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else begin
      waitrequest <= !(req && waitrequest);
      if (req && waitrequest) begin
        readdata <= next_rdata;
      end
    end
  end

  // Configuration registers with byte lanes, returned to reset values by the sync pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mode_config    <= ashs_pkg::MODE_RESET;
      gain_config_a  <= ashs_pkg::GAIN_RESET;
      gain_config_b  <= ashs_pkg::GAIN_RESET;
      config_reg     <= ashs_pkg::CFG_RESET;
      channel_config <= ashs_pkg::CHCFG_RESET;
      clock_config   <= ashs_pkg::CLOCK_RESET;
    end else if (soft_rst) begin
      mode_config    <= ashs_pkg::MODE_RESET;
      gain_config_a  <= ashs_pkg::GAIN_RESET;
      gain_config_b  <= ashs_pkg::GAIN_RESET;
      config_reg     <= ashs_pkg::CFG_RESET;
      channel_config <= ashs_pkg::CHCFG_RESET;
      clock_config   <= ashs_pkg::CLOCK_RESET;
    end else begin
      if (wr_mode) mode_config <= (mode_config & ~bmask) | (writedata & bmask);
      if (wr_gna) gain_config_a <= (gain_config_a & ~bmask) | (writedata & bmask);
      if (wr_gnb) gain_config_b <= (gain_config_b & ~bmask) | (writedata & bmask);
      if (wr_cfg) config_reg <= (config_reg & ~bmask) | (writedata & bmask);
      if (wr_chc) channel_config <= (channel_config & ~bmask) | (writedata & bmask);
      if (wr_clk) clock_config <= (clock_config & ~bmask) | (writedata & bmask);
    end
  end

  // Oversampling counter, held at zero while stopped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      mod_count <= 14'h0000;
    end else if (!run) begin
      mod_count <= 14'h0000;
    end else if (mod_tick) begin
      mod_count <= (mod_count >= ovs_last) ? 14'h0000 : 14'(mod_count + 14'h0001);
    end
  end

  // Capture sample and frame check; all channels share one instant
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sample    <= 24'h00_0000;
      crc_value <= 16'h0000;
    end else if (sample_tick) begin
      sample    <= code_s2;
      crc_value <= crc16(code_s2, ccitt);
    end
  end

  // Ready flag: new sample sets it and wins over the data read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ready              <= 1'b0;
      conversion_ready_n <= 1'b1;
    end else begin
      ready              <= sample_tick || (ready && !rd_data && !soft_rst);
      conversion_ready_n <= !(sample_tick || (ready && !rd_data && !soft_rst));
    end
  end

  // Sticky events, write one to clear, mask onto the interrupt
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status <= 32'h0000_0000;
      irq_mask   <= 32'h0000_0000;
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_st;
      if (wr_imk) irq_mask <= (irq_mask & ~bmask) | (writedata & bmask);
      irq        <= next_irq;
    end
  end

  // Helper: cycles since the last conversion under a steady setting
  logic [15:0] gap;
  logic        gap_ok;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gap    <= 16'h0000;
      gap_ok <= 1'b0;
    end else begin
      gap    <= sample_tick ? 16'h0000 : 16'(gap + 16'h0001);
      gap_ok <= run && !wr_clk && (gap_ok || sample_tick);
    end
  end

  // Stopped oscillator gives no conversions
  stopped_no_sample_a: assert property (@(posedge clk) disable iff (reset)
    !osc_en |-> !sample_tick ##1 (!mod_tick && mod_count == 14'h0000))
    else $error("conversion while oscillator stopped");

  // Ready line falls the cycle after a conversion
  ready_falls_a: assert property (@(posedge clk) disable iff (reset)
    sample_tick |=> !conversion_ready_n && ready)
    else $error("ready line not low after conversion");

  // Ready line rises after the data word is read
  ready_rises_a: assert property (@(posedge clk) disable iff (reset)
    rd_data && !sample_tick |=> conversion_ready_n && !ready)
    else $error("ready line not high after data read");

  // Ready line stays high with no conversion pending
  ready_idle_a: assert property (@(posedge clk) disable iff (reset)
    conversion_ready_n && !sample_tick |=> conversion_ready_n)
    else $error("ready line fell without conversion");

  // Frame check matches captured word
  frame_check_a: assert property (@(posedge clk) disable iff (reset)
    sample_tick |=> crc_value == crc16(sample, $past(ccitt)))
    else $error("frame check mismatch");

  // Ratio 512 at 4 MHz gives 1280 system clocks per conversion
  sample_rate_a: assert property (@(posedge clk) disable iff (reset)
    sample_tick && gap_ok && ovs_code == ashs_pkg::OVS_512 |-> gap == 16'd1279)
    else $error("conversion period wrong for ratio 512");

  // Enabling the oscillator starts conversions promptly
  osc_start_a: assert property (@(posedge clk) disable iff (reset)
    $rose(run) && ovs_code == 3'h0 |-> ##[300:330] sample_tick)
    else $error("no conversion after oscillator enable");

  // Ratio 128 at 4 MHz gives 320 system clocks per conversion
  sample_rate_short_a: assert property (@(posedge clk) disable iff (reset)
    sample_tick && gap_ok && ovs_code == 3'h0 |-> gap == 16'h013F)
    else $error("conversion period wrong for ratio 128");

  // Oversampling counter steps once per modulator tick
  count_step_a: assert property (@(posedge clk) disable iff (reset)
    run && mod_tick && mod_count < ovs_last |=> mod_count == 14'($past(mod_count) + 14'h0001))
    else $error("oversampling counter did not step");

  // Sync pin clears the ready line and the counter
  soft_clear_a: assert property (@(posedge clk) disable iff (reset)
    soft_rst |=> conversion_ready_n && !ready && mod_count == 14'h0000)
    else $error("sync pin did not clear conversion state");

  // Captured word and frame check hold between conversions
  frame_hold_a: assert property (@(posedge clk) disable iff (reset)
    !sample_tick |=> $stable(crc_value) && $stable(sample))
    else $error("captured word changed without conversion");

  // Conversion and overrun events are latched
  event_latch_a: assert property (@(posedge clk) disable iff (reset)
    sample_tick |=> irq_status[ashs_pkg::EV_READY_BIT] && (irq_status[ashs_pkg::EV_OVERRUN_BIT] || !$past(ready)))
    else $error("conversion event not latched");
endmodule // ashs_converter

/* File: hdl/ashs_frac_div.sv */
// Fractional clock-enable divider
`timescale 1ns/1ns
module ashs_frac_div #(
  parameter int INC = 4,
  parameter int MOD = 10
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Control
  input  wire logic run,
  // Enable pulse
  output logic      tick
);
  localparam logic [15:0] INC_W = 16'(INC);
  localparam logic [15:0] MOD_W = 16'(MOD);

  logic [15:0] acc;
  wire  [15:0] sum  = acc + INC_W;
  wire         wrap = (sum >= MOD_W);

  // Average rate INC/MOD of clk, cleared while stopped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      acc  <= 16'h0000;
      tick <= 1'b0;
    end else begin
      acc  <= !run ? 16'h0000 : (wrap ? 16'(sum - MOD_W) : sum);
      tick <= run && wrap;
    end
  end
endmodule // ashs_frac_div

/* File: hdl/ashs_pkg.sv */
// Shared constants for the sampling converter register block
package ashs_pkg;
  // Clock rates in kHz
  localparam int CLK_KHZ     = 10000;
  localparam int CRYSTAL_KHZ = 8000;
  localparam int MOD_KHZ     = CRYSTAL_KHZ / 2;

  // Register word indices, byte address is four times the index
  localparam logic [3:0] ADDR_ID     = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_MODE   = 4'h2;
  localparam logic [3:0] ADDR_GAIN_A = 4'h3;
  localparam logic [3:0] ADDR_GAIN_B = 4'h4;
  localparam logic [3:0] ADDR_CONFIG = 4'h5;
  localparam logic [3:0] ADDR_CHCFG  = 4'h6;
  localparam logic [3:0] ADDR_CLOCK  = 4'h7;
  localparam logic [3:0] ADDR_DATA   = 4'h8;
  localparam logic [3:0] ADDR_CRC    = 4'h9;
  localparam logic [3:0] ADDR_IRQ_ST = 4'hA;
  localparam logic [3:0] ADDR_IRQ_MK = 4'hB;

  // Status fields
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_RUN_BIT   = 1;
  // Mode fields
  localparam int MODE_CRC_BIT   = 0;
  localparam int MODE_WLEN_LSB  = 1;
  // Clock fields
  localparam int CLK_CH_LSB     = 0;
  localparam int CLK_OSC_BIT    = 8;
  localparam int CLK_OVS_LSB    = 9;
  // Interrupt event bits
  localparam int EV_READY_BIT   = 0;
  localparam int EV_OVERRUN_BIT = 1;

  // Reset values
  localparam logic [31:0] MODE_RESET  = 32'h0000_0002;
  localparam logic [31:0] GAIN_RESET  = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [31:0] CHCFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CLOCK_RESET = 32'h0000_45FF;

  // Word length codes
  localparam logic [1:0] WLEN_16   = 2'h0;
  localparam logic [1:0] WLEN_24   = 2'h1;
  localparam logic [1:0] WLEN_32Z  = 2'h2;
  // Oversampling: length is base shifted left by code
  localparam logic [14:0] OVS_BASE = 15'h0080;
  localparam logic [2:0]  OVS_512  = 3'h2;
  // Frame check polynomials and seed
  localparam logic [15:0] CRC_CCITT = 16'h1021;
  localparam logic [15:0] CRC_ANSI  = 16'h8005;
  localparam logic [15:0] CRC_SEED  = 16'hFFFF;
endpackage

/* File: test/ashs_pin_host.sv */
// Host-side pin model: reset pulse and held sample code
`timescale 1ns/1ns
module ashs_pin_host #(
  parameter logic [23:0] SAMPLE = 24'h3A5C71
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Bench request
  input  wire logic        pulse,
  // Converter pins
  output logic             sync_reset_n,
  output logic      [23:0] analog_code
);
  logic [2:0] low_cnt;

  // Hold the pin low four cycles per request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      low_cnt <= 3'h0;
    end else if (pulse) begin
      low_cnt <= 3'h4;
    end else if (low_cnt != 3'h0) begin
      low_cnt <= low_cnt - 3'h1;
    end
  end

  // Pin levels
  assign sync_reset_n = (low_cnt == 3'h0);
  assign analog_code  = SAMPLE;
endmodule // ashs_pin_host

/* File: test/testbench.sv */
// Self-checking bench for the converter register block
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  localparam logic [23:0] SAMPLE = 24'hC35A71;
  localparam logic [31:0] ID_VAL = 32'h0000_1234; // Arbitrary value
  logic        clk, reset, read, write, pulse;
  logic [3:0]  address, byteenable;
  logic [31:0] writedata, readdata, q;
  logic        waitrequest, sync_reset_n, conversion_ready_n, irq;
  logic [23:0] analog_code;
  int          n_fail, comparisons, cyc, t0;

  ashs_converter #(.DEVICE_ID(ID_VAL)) u_dut (
    .clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .sync_reset_n(sync_reset_n), .analog_code(analog_code),
    .conversion_ready_n(conversion_ready_n), .irq(irq));
  ashs_pin_host #(.SAMPLE(SAMPLE)) u_host (
    .clk(clk), .reset(reset), .pulse(pulse), .sync_reset_n(sync_reset_n),
    .analog_code(analog_code));

  // Closing report
  task automatic stop_test;
    $display("mismatches=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Frame check reference, MSB first from the seed
  function automatic logic [15:0] crc_ref(input logic [23:0] d, input logic [15:0] p);
    logic [15:0] c;
    c = ashs_pkg::CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? p : 16'h0000);
    end
    return c;
  endfunction

  // One bus transfer held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a; writedata <= d; write <= wr; read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    q = readdata;
    read <= 1'b0; write <= 1'b0;
    if (n >= 100) begin
      n_fail++;
      stop_test();
    end
  endtask

  // Wait for the ready line to reach a level, bounded
  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (conversion_ready_n !== v && n < 3000) begin
      @(posedge clk);
      n++;
    end
    `CHK(conversion_ready_n, v)
  endtask

  // Reset values and unmapped place
  task automatic t_reset;
    bus(0, ashs_pkg::ADDR_ID, 32'h0); `CHK(q, ID_VAL)
    bus(0, ashs_pkg::ADDR_MODE, 32'h0); `CHK(q, ashs_pkg::MODE_RESET)
    bus(0, ashs_pkg::ADDR_CLOCK, 32'h0); `CHK(q, ashs_pkg::CLOCK_RESET)
    bus(0, 4'hC, 32'h0); `CHK(q, 32'h0)
    `CHK(conversion_ready_n, 1'b1)
  endtask

  // Oscillator stopped: no samples
  task automatic t_stop;
    int lows;
    lows = 0;
    bus(1, ashs_pkg::ADDR_CLOCK, 32'h0000_44FF);
    repeat (1500) begin
      @(posedge clk);
      if (conversion_ready_n !== 1'b1) lows++;
    end
    `CHK(lows, 0)
    bus(0, ashs_pkg::ADDR_STATUS, 32'h0); `CHK(q, 32'h0)
  endtask

  // Configuration written while stopped
  task automatic t_config;
    bus(1, ashs_pkg::ADDR_MODE, 32'h3);
    bus(0, ashs_pkg::ADDR_MODE, 32'h0); `CHK(q, 32'h3)
    for (int i = 3; i <= 6; i++) begin
      bus(1, 4'(i), 32'h0000_0100 + 32'(i));
      bus(0, 4'(i), 32'h0); `CHK(q, 32'h0000_0100 + 32'(i))
    end
    byteenable <= 4'h1;
    bus(1, ashs_pkg::ADDR_GAIN_B, 32'hFFFF_FFAA);
    byteenable <= 4'hF;
    bus(0, ashs_pkg::ADDR_GAIN_B, 32'h0); `CHK(q, 32'h0000_01AA)
    bus(0, ashs_pkg::ADDR_CLOCK, 32'h0); `CHK(q, 32'h0000_44FF)
    `CHK(conversion_ready_n, 1'b1)
  endtask

  // Start, sample word and conversion period
  task automatic t_start;
    bus(1, ashs_pkg::ADDR_CLOCK, 32'h0000_45FF);
    wait_lvl(1'b0);
    t0 = cyc;
    bus(0, ashs_pkg::ADDR_STATUS, 32'h0); `CHK(q, 32'h3)
    bus(0, ashs_pkg::ADDR_DATA, 32'h0); `CHK(q, {8'h00, SAMPLE})
    bus(0, ashs_pkg::ADDR_CRC, 32'h0); `CHK(q, {16'h0000, crc_ref(SAMPLE, ashs_pkg::CRC_CCITT)})
    bus(1, ashs_pkg::ADDR_MODE, 32'h1);
    bus(0, ashs_pkg::ADDR_DATA, 32'h0); `CHK(q, {16'h0000, SAMPLE[23:8]})
    bus(1, ashs_pkg::ADDR_MODE, 32'h5);
    bus(0, ashs_pkg::ADDR_DATA, 32'h0); `CHK(q, {SAMPLE, 8'h00})
    bus(1, ashs_pkg::ADDR_MODE, 32'h7);
    bus(0, ashs_pkg::ADDR_DATA, 32'h0); `CHK(q, {{8{SAMPLE[23]}}, SAMPLE})
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    `CHK(cyc - t0, 1280)
  endtask

  // Overrun, mask and write-one-to-clear
  task automatic t_irq;
    repeat (1290) @(posedge clk);
    bus(0, ashs_pkg::ADDR_IRQ_ST, 32'h0); `CHK(q, 32'h3)
    `CHK(irq, 1'b0)
    bus(1, ashs_pkg::ADDR_IRQ_MK, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    bus(1, ashs_pkg::ADDR_IRQ_ST, 32'h3);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(0, ashs_pkg::ADDR_IRQ_ST, 32'h0); `CHK(q, 32'h0)
  endtask

  // Pin reset returns configuration to defaults
  task automatic t_sync;
    @(posedge clk) pulse <= 1'b1;
    @(posedge clk) pulse <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK(conversion_ready_n, 1'b1)
    bus(0, ashs_pkg::ADDR_MODE, 32'h0); `CHK(q, ashs_pkg::MODE_RESET)
    bus(0, ashs_pkg::ADDR_CLOCK, 32'h0); `CHK(q, ashs_pkg::CLOCK_RESET)
    bus(1, ashs_pkg::ADDR_CLOCK, 32'h0000_40FF);
    bus(1, ashs_pkg::ADDR_CLOCK, 32'h0000_41FF);
    wait_lvl(1'b0);
    t0 = cyc;
    bus(0, ashs_pkg::ADDR_CRC, 32'h0); `CHK(q, {16'h0000, crc_ref(SAMPLE, ashs_pkg::CRC_ANSI)})
    bus(0, ashs_pkg::ADDR_DATA, 32'h0); `CHK(q, {8'h00, SAMPLE})
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    `CHK(cyc - t0, 320)
  endtask

  // Clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Cycle count and timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    n_fail = 0; comparisons = 0; cyc = 0;
    reset = 1'b1; read = 1'b0; write = 1'b0; pulse = 1'b0;
    address = 4'h0; writedata = 32'h0; byteenable = 4'hF;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_stop();
    t_config();
    t_start();
    t_irq();
    t_sync();
    stop_test();
  end
endmodule // testbench
